// ### logic/pdc_capfield.sv
// Payload capability and error-role fields with strap and override loading.
`timescale 1ns/1ps
module pdc_capfield
   import pdc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic en,
   input wire logic strap_large,
   input wire logic ovr_load,
   input wire logic [2:0] ovr_mps,
   input wire logic ovr_rber,
   output logic [2:0] mps,
   output logic rber
);
   // Counts edges after reset release until the synchronised strap is valid.
   logic [1:0] settle_cnt_ff;
   // Supported payload code and role-based reporting bit.
   logic [2:0] mps_ff;
   logic rber_ff;

   // The settle counter saturates one past the load point, so it loads once.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         settle_cnt_ff <= 2'h0;
      end else if (en && settle_cnt_ff != 2'h3) begin
         settle_cnt_ff <= settle_cnt_ff + 2'h1;
      end
   end

   // The strap is caught after release because an async reset takes constants only.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         mps_ff <= MPS_RST_SMALL;
      end else if (en) begin
         if (ovr_load) begin
            mps_ff <= ovr_mps;
         end else if (settle_cnt_ff == STRAP_SETTLE) begin
            mps_ff <= strap_large ? MPS_RST_LARGE : MPS_RST_SMALL;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rber_ff <= RBER_RST;
      end else if (en && ovr_load) begin
         rber_ff <= ovr_rber;
      end
   end

   assign mps = mps_ff;
   assign rber = rber_ff;
endmodule

// ### logic/pdc_pkg.sv
// Shared constants for the device capability and control register bank.
package pdc_pkg;

   // ------------------------------------------------------------------
   // Bus geometry and register byte offsets.
   // ------------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] OFS_DEV_CAP = 8'hC4;
   localparam logic [7:0] OFS_DEV_CTL = 8'hC8;

   // ------------------------------------------------------------------
   // Capability field positions.
   // ------------------------------------------------------------------
   localparam int unsigned CAP_MPS_LSB = 0;
   localparam int unsigned CAP_RBER_BIT = 15;
   localparam int unsigned CAP_SPLV_LSB = 18;
   localparam int unsigned CAP_SPLS_LSB = 26;

   // ------------------------------------------------------------------
   // Control field positions.
   // ------------------------------------------------------------------
   localparam int unsigned CTL_ERR_LSB = 0;
   localparam int unsigned CTL_MPS_LSB = 5;
   localparam int unsigned CTL_AUX_BIT = 10;

   // ------------------------------------------------------------------
   // Reset values.
   // ------------------------------------------------------------------
   localparam logic [2:0] MPS_RST_SMALL = 3'h1;
   localparam logic [2:0] MPS_RST_LARGE = 3'h2;
   localparam logic RBER_RST = 1'b1;
   localparam logic [7:0] SPLV_RST = 8'h00;
   localparam logic [1:0] SPLS_RST = 2'h0;
   localparam logic [3:0] ERR_EN_RST = 4'h0;
   localparam logic [2:0] CTL_MPS_RST = 3'h0;
   localparam logic AUX_RST = 1'b0;

   // ------------------------------------------------------------------
   // Timing and bus answer codes.
   // ------------------------------------------------------------------
   localparam logic [1:0] STRAP_SETTLE = 2'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### logic/pdc_regs.sv
// Device capability and device control registers behind an AXI4-Lite slave.
`timescale 1ns/1ps

module pdc_regs
   import pdc_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST_B,
   input wire logic PWR_ON_RST_B,
   input wire logic CLK_EN,
   input wire logic LARGE_PAYLOAD_STRAP,
   input wire logic UPSTREAM_PORT,
   input wire logic OVR_LOAD,
   input wire logic [2:0] OVR_MPS,
   input wire logic OVR_RBER,
   input wire logic SPL_MSG_VALID,
   input wire logic [7:0] SPL_MSG_VALUE,
   input wire logic [1:0] SPL_MSG_SCALE,
   input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic [2:0] S_AXI_AWPROT,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic [2:0] S_AXI_ARPROT,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   output logic COR_ERR_REPORT_EN,
   output logic NONFATAL_ERR_REPORT_EN,
   output logic FATAL_ERR_REPORT_EN,
   output logic UR_REPORT_EN,
   output logic [2:0] MAX_PAYLOAD,
   output logic [2:0] MAX_PAYLOAD_CAP,
   output logic AUX_PWR_EN,
   output logic [7:0] SLOT_PWR_VALUE,
   output logic [1:0] SLOT_PWR_SCALE
);

   // ------------------------------------------------------------------
   // Decode helpers
   // ------------------------------------------------------------------

   // True when the byte address names one of the two words of this bank.
   function automatic logic addr_hit(input logic [ADDR_W-1:0] addr);
      return (addr == OFS_DEV_CAP) || (addr == OFS_DEV_CTL);
   endfunction

   // A request above what the port supports is pulled down to the support.
   function automatic logic [2:0] clamp_mps(input logic [2:0] req, input logic [2:0] cap);
      return (req > cap) ? cap : req;
   endfunction

   // ------------------------------------------------------------------
   // Internal state
   // ------------------------------------------------------------------

   // Synchronised pin levels: bit 0 is the payload strap, bit 1 upstream.
   logic [1:0] pin_sync;
   // Capability fields kept by the strap and override unit.
   logic [2:0] cap_mps;
   logic cap_rber;

   // Write address and data holding, kept apart so either may arrive first.
   logic aw_held_ff;
   logic w_held_ff;
   logic [ADDR_W-1:0] wr_addr_ff;
   logic [31:0] wr_data_ff;
   logic [3:0] wr_strb_ff;
   logic awready_ff;
   logic wready_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;

   // Read channel state.
   logic arready_ff;
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;

   // Control register fields that hold storage.
   logic [3:0] err_en_ff;
   logic [2:0] ctl_mps_ff;
   logic aux_en_ff;

   // Captured slot power limit from the upstream message.
   logic [7:0] splv_ff;
   logic [1:0] spls_ff;

   // One cycle in which both halves of a write are present and no answer waits.
   logic wr_fire;
   // The handshakes that close a write or a read answer.
   logic b_done;
   logic r_done;
   // A control-word write in the firing cycle, per byte lane.
   logic ctl_wr_lo;
   logic ctl_wr_hi;

   assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
   assign b_done = bvalid_ff && S_AXI_BREADY;
   assign r_done = rvalid_ff && S_AXI_RREADY;
   assign ctl_wr_lo = wr_fire && (wr_addr_ff == OFS_DEV_CTL) && wr_strb_ff[0];
   assign ctl_wr_hi = wr_fire && (wr_addr_ff == OFS_DEV_CTL) && wr_strb_ff[1];

   // ------------------------------------------------------------------
   // Pin synchronisation and capability fields
   // ------------------------------------------------------------------

   // Both straps come from pins, so they pass two flip-flops first.
   pdc_sync #(
      .WIDTH(2)
   ) u_pin_sync (
      .clk(SYS_CLK),
      .rst_b(RST_B),
      .en(CLK_EN),
      .d({UPSTREAM_PORT, LARGE_PAYLOAD_STRAP}),
      .q(pin_sync)
   );

   // The override strobe comes from on-chip management logic on this clock.
   pdc_capfield u_capfield (
      .clk(SYS_CLK),
      .rst_b(RST_B),
      .en(CLK_EN),
      .strap_large(pin_sync[0]),
      .ovr_load(OVR_LOAD),
      .ovr_mps(OVR_MPS),
      .ovr_rber(OVR_RBER),
      .mps(cap_mps),
      .rber(cap_rber)
   );

   // ------------------------------------------------------------------
   // Write address channel
   // ------------------------------------------------------------------

   // Ready drops on the handshake and reopens only once the answer is taken,
   // which keeps at most one write in the bank at a time.
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         awready_ff <= 1'b1;
         aw_held_ff <= 1'b0;
         wr_addr_ff <= '0;
      end else if (CLK_EN) begin
         if (S_AXI_AWVALID && awready_ff) begin
            awready_ff <= 1'b0;
            aw_held_ff <= 1'b1;
            wr_addr_ff <= S_AXI_AWADDR;
         end else if (wr_fire) begin
            aw_held_ff <= 1'b0;
         end else if (b_done) begin
            awready_ff <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // Write data channel
   // ------------------------------------------------------------------

   // Same pattern as the address side, so the data may come first.
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         wready_ff <= 1'b1;
         w_held_ff <= 1'b0;
         wr_data_ff <= 32'h0000_0000;
         wr_strb_ff <= 4'h0;
      end else if (CLK_EN) begin
         if (S_AXI_WVALID && wready_ff) begin
            wready_ff <= 1'b0;
            w_held_ff <= 1'b1;
            wr_data_ff <= S_AXI_WDATA;
            wr_strb_ff <= S_AXI_WSTRB;
         end else if (wr_fire) begin
            w_held_ff <= 1'b0;
         end else if (b_done) begin
            wready_ff <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // Write response channel
   // ------------------------------------------------------------------

   // A write to the read-only capability word is accepted and ignored;
   // only an address outside the bank earns an error answer.
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         bvalid_ff <= 1'b0;
         bresp_ff <= RESP_OKAY;
      end else if (CLK_EN) begin
         if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= addr_hit(wr_addr_ff) ? RESP_OKAY : RESP_SLVERR;
         end else if (b_done) begin
            bvalid_ff <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------------
   // Device control storage
   // ------------------------------------------------------------------

   // The four reporting enables sit in the low byte lane.
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         err_en_ff <= ERR_EN_RST;
      end else if (CLK_EN) begin
         if (ctl_wr_lo) begin
            err_en_ff <= wr_data_ff[CTL_ERR_LSB +: 4];
         end
      end
   end

   // The payload size shares the low lane; it is checked against the
   // capability at write time only, so a later lower override leaves it.
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         ctl_mps_ff <= CTL_MPS_RST;
      end else if (CLK_EN) begin
         if (ctl_wr_lo) begin
            ctl_mps_ff <= clamp_mps(wr_data_ff[CTL_MPS_LSB +: 3], cap_mps);
         end
      end
   end

   // The sticky enable survives port resets and only power-on clears it.
   always_ff @(posedge SYS_CLK or negedge PWR_ON_RST_B) begin
      if (!PWR_ON_RST_B) begin
         aux_en_ff <= AUX_RST;
      end else if (CLK_EN) begin
         if (ctl_wr_hi) begin
            aux_en_ff <= wr_data_ff[CTL_AUX_BIT];
         end
      end
   end

   // ------------------------------------------------------------------
   // Captured slot power limit
   // ------------------------------------------------------------------

   // Only the upstream port takes the message; downstream ports hold the last captured value, zero from reset.
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         splv_ff <= SPLV_RST;
         spls_ff <= SPLS_RST;
      end else if (CLK_EN) begin
         if (SPL_MSG_VALID && pin_sync[1]) begin
            splv_ff <= SPL_MSG_VALUE;
            spls_ff <= SPL_MSG_SCALE;
         end
      end
   end

   // ------------------------------------------------------------------
   // Read data assembly
   // ------------------------------------------------------------------

   // Builds the word for a read address; every bit not named is zero.
   function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] addr);
      logic [31:0] w;
      w = 32'h0000_0000;
      if (addr == OFS_DEV_CAP) begin
         w[CAP_MPS_LSB +: 3] = cap_mps;
         w[CAP_RBER_BIT] = cap_rber;
         w[CAP_SPLV_LSB +: 8] = splv_ff;
         w[CAP_SPLS_LSB +: 2] = spls_ff;
      end else if (addr == OFS_DEV_CTL) begin
         // tag and phantom enables read zero.
         w[CTL_ERR_LSB +: 4] = err_en_ff;
         w[CTL_MPS_LSB +: 3] = ctl_mps_ff;
         w[CTL_AUX_BIT] = aux_en_ff;
      end
      return w;
   endfunction

   // ------------------------------------------------------------------
   // Read channel
   // ------------------------------------------------------------------

   // Data is sampled at the address handshake and then held steady until
   // the master takes it, so a register change mid-answer cannot tear it.
   always_ff @(posedge SYS_CLK or negedge RST_B) begin
      if (!RST_B) begin
         arready_ff <= 1'b1;
         rvalid_ff <= 1'b0;
         rdata_ff <= 32'h0000_0000;
         rresp_ff <= RESP_OKAY;
      end else if (CLK_EN) begin
         if (S_AXI_ARVALID && arready_ff) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= read_word(S_AXI_ARADDR);
            rresp_ff <= addr_hit(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
         end else if (r_done) begin
            rvalid_ff <= 1'b0;
            arready_ff <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------

   // Every output is a flip-flop of this block or of its field unit.
   assign S_AXI_AWREADY = awready_ff;
   assign S_AXI_WREADY = wready_ff;
   assign S_AXI_BVALID = bvalid_ff;
   assign S_AXI_BRESP = bresp_ff;
   assign S_AXI_ARREADY = arready_ff;
   assign S_AXI_RVALID = rvalid_ff;
   assign S_AXI_RDATA = rdata_ff;
   assign S_AXI_RRESP = rresp_ff;
   assign COR_ERR_REPORT_EN = err_en_ff[0];
   assign NONFATAL_ERR_REPORT_EN = err_en_ff[1];
   assign FATAL_ERR_REPORT_EN = err_en_ff[2];
   assign UR_REPORT_EN = err_en_ff[3];
   assign MAX_PAYLOAD = ctl_mps_ff;
   assign MAX_PAYLOAD_CAP = cap_mps;
   assign AUX_PWR_EN = aux_en_ff;
   assign SLOT_PWR_VALUE = splv_ff;
   assign SLOT_PWR_SCALE = spls_ff;

endmodule

// ### logic/pdc_sync.sv
// Two-stage synchroniser for pin-level inputs.
`timescale 1ns/1ps
module pdc_sync #(
   parameter int unsigned WIDTH = 2
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic en,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   // First stage feeds only the second stage.
   logic [WIDTH-1:0] meta_ff;
   // Second stage is the only value the block logic reads.
   logic [WIDTH-1:0] sync_ff;

   // Both stages share the clock enable so they freeze together.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else if (en) begin
         meta_ff <= d;
         sync_ff <= meta_ff;
      end
   end

   assign q = sync_ff;
endmodule

// ### tb/pdc_regs_checker.sv
// Concurrent checks on the control fields and capability inputs of the register bank.
`timescale 1ns/1ps
module pdc_regs_checker
   import pdc_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST_B,
   input wire logic PWR_ON_RST_B,
   input wire logic CLK_EN,
   input wire logic UPSTREAM_PORT,
   input wire logic OVR_LOAD,
   input wire logic [2:0] OVR_MPS,
   input wire logic SPL_MSG_VALID,
   input wire logic [7:0] SPL_MSG_VALUE,
   input wire logic [1:0] SPL_MSG_SCALE,
   input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   input wire logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   input wire logic S_AXI_WREADY,
   input wire logic COR_ERR_REPORT_EN,
   input wire logic NONFATAL_ERR_REPORT_EN,
   input wire logic FATAL_ERR_REPORT_EN,
   input wire logic UR_REPORT_EN,
   input wire logic [2:0] MAX_PAYLOAD,
   input wire logic [2:0] MAX_PAYLOAD_CAP,
   input wire logic AUX_PWR_EN,
   input wire logic [7:0] SLOT_PWR_VALUE,
   input wire logic [1:0] SLOT_PWR_SCALE
);
   // ------------------------------------------------------------------
   // Clocking and the shared write and slot power message sequences.
   // ------------------------------------------------------------------
   default clocking dcb @(posedge SYS_CLK);
   endclocking
   default disable iff (!RST_B);

   // Both halves of a control write taken at one edge; the field lands two edges on.
   sequence ctl_wr_s;
      CLK_EN && S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY && S_AXI_AWADDR == OFS_DEV_CTL;
   endsequence
   sequence lane0_wr_s;
      ctl_wr_s ##0 S_AXI_WSTRB[0];
   endsequence
   // A message only counts once the port role has settled through the synchroniser.
   sequence spl_ok_s;
      (RST_B && UPSTREAM_PORT)[*4] ##0 (CLK_EN && SPL_MSG_VALID);
   endsequence

   // ------------------------------------------------------------------
   // Assertions.
   // ------------------------------------------------------------------
   reset_vals_a: assert property ($rose(RST_B) |-> MAX_PAYLOAD == CTL_MPS_RST
      && MAX_PAYLOAD_CAP == MPS_RST_SMALL && !COR_ERR_REPORT_EN && !UR_REPORT_EN && SLOT_PWR_VALUE == SPLV_RST)
      else $error("control fields not at reset values");
   err_enables_a: assert property (lane0_wr_s |-> ##2 {UR_REPORT_EN, FATAL_ERR_REPORT_EN,
      NONFATAL_ERR_REPORT_EN, COR_ERR_REPORT_EN} == $past(S_AXI_WDATA[3:0], 2))
      else $error("error enables do not follow write");
   payload_pass_a: assert property (lane0_wr_s ##0 S_AXI_WDATA[7:5] <= MAX_PAYLOAD_CAP
      |-> ##2 MAX_PAYLOAD == $past(S_AXI_WDATA[7:5], 2))
      else $error("payload size not stored");
   payload_clamp_a: assert property (lane0_wr_s ##0 S_AXI_WDATA[7:5] > MAX_PAYLOAD_CAP
      |-> ##2 MAX_PAYLOAD == $past(MAX_PAYLOAD_CAP, 2))
      else $error("oversized payload not clamped");
   aux_write_a: assert property (ctl_wr_s ##0 S_AXI_WSTRB[1] |-> ##2 AUX_PWR_EN == $past(S_AXI_WDATA[10], 2))
      else $error("aux power enable not written");
   aux_sticky_a: assert property (disable iff (!PWR_ON_RST_B) !RST_B |-> $stable(AUX_PWR_EN))
      else $error("aux power enable lost in port reset");
   cap_override_a: assert property (CLK_EN && OVR_LOAD |=> MAX_PAYLOAD_CAP == $past(OVR_MPS))
      else $error("capability override not loaded");
   slot_capture_a: assert property (spl_ok_s |=> SLOT_PWR_VALUE == $past(SPL_MSG_VALUE)
      && SLOT_PWR_SCALE == $past(SPL_MSG_SCALE))
      else $error("slot power message not captured");
endmodule

bind pdc_regs pdc_regs_checker u_chk (.SYS_CLK(SYS_CLK), .RST_B(RST_B), .PWR_ON_RST_B(PWR_ON_RST_B),
   .CLK_EN(CLK_EN), .UPSTREAM_PORT(UPSTREAM_PORT), .OVR_LOAD(OVR_LOAD), .OVR_MPS(OVR_MPS),
   .SPL_MSG_VALID(SPL_MSG_VALID), .SPL_MSG_VALUE(SPL_MSG_VALUE), .SPL_MSG_SCALE(SPL_MSG_SCALE),
   .S_AXI_AWADDR(S_AXI_AWADDR), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
   .S_AXI_WDATA(S_AXI_WDATA), .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID),
   .S_AXI_WREADY(S_AXI_WREADY), .COR_ERR_REPORT_EN(COR_ERR_REPORT_EN),
   .NONFATAL_ERR_REPORT_EN(NONFATAL_ERR_REPORT_EN), .FATAL_ERR_REPORT_EN(FATAL_ERR_REPORT_EN),
   .UR_REPORT_EN(UR_REPORT_EN), .MAX_PAYLOAD(MAX_PAYLOAD), .MAX_PAYLOAD_CAP(MAX_PAYLOAD_CAP),
   .AUX_PWR_EN(AUX_PWR_EN), .SLOT_PWR_VALUE(SLOT_PWR_VALUE), .SLOT_PWR_SCALE(SLOT_PWR_SCALE));

// ### tb/pdc_regs_tb.sv
// Self-checking bench for the device capability and control register bank.
`timescale 1ns/1ps
module pdc_regs_tb
   import pdc_pkg::*;
;
   // ------------------------------------------------------------------
   // Stimulus and observed signals.
   // ------------------------------------------------------------------
   logic clk, rst_b, por_b, clk_en, strap, upstream, ovr_load, ovr_rber, spl_valid;
   logic [2:0] ovr_mps;
   logic [7:0] spl_value, awaddr, araddr, slot_value;
   logic [1:0] spl_scale, bresp, rresp, slot_scale;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
   logic cor, nonfatal, fatal, ur, aux;
   logic [2:0] mps, mps_cap;
   int fails;
   int n_checks;

   pdc_regs uut (.SYS_CLK(clk), .RST_B(rst_b), .PWR_ON_RST_B(por_b), .CLK_EN(clk_en),
      .LARGE_PAYLOAD_STRAP(strap), .UPSTREAM_PORT(upstream), .OVR_LOAD(ovr_load), .OVR_MPS(ovr_mps),
      .OVR_RBER(ovr_rber), .SPL_MSG_VALID(spl_valid), .SPL_MSG_VALUE(spl_value), .SPL_MSG_SCALE(spl_scale),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .COR_ERR_REPORT_EN(cor),
      .NONFATAL_ERR_REPORT_EN(nonfatal), .FATAL_ERR_REPORT_EN(fatal), .UR_REPORT_EN(ur),
      .MAX_PAYLOAD(mps), .MAX_PAYLOAD_CAP(mps_cap), .AUX_PWR_EN(aux), .SLOT_PWR_VALUE(slot_value),
      .SLOT_PWR_SCALE(slot_scale));

   // Free-running 40 MHz clock.
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // ------------------------------------------------------------------
   // Shared tasks.
   // ------------------------------------------------------------------
   // Control pins packed into the control register image.
   function automatic logic [31:0] ctl_img();
      return {21'h0, aux, 2'h0, mps, 1'b0, ur, fatal, nonfatal, cor};
   endfunction

   task automatic end_sim();
      $display("Checks made %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
         fails++;
      end
   endtask

   // A bus answer that never comes ends the run here.
   task automatic hang(input string nm);
      $display("MISMATCH %s expected answer seen none", nm);
      fails++;
      end_sim();
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Address and data are offered together and each is dropped once taken.
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
      int n;
      n = 0;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid && n < 64);
      bready <= 1'b0;
      if (!bvalid) hang("bvalid");
      chk("bresp", {30'h0, er}, {30'h0, bresp});
      // One idle edge keeps the next call from driving the same signals in this step.
      @(posedge clk);
   endtask

   task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er, input string nm);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid && n < 64);
      rready <= 1'b0;
      if (!rvalid) hang("rvalid");
      chk(nm, ed, rdata);
      chk("rresp", {30'h0, er}, {30'h0, rresp});
      @(posedge clk);
   endtask

   task automatic port_reset();
      rst_b <= 1'b0;
      cyc(2);
      rst_b <= 1'b1;
      // The strap and role settle by the third enabled edge.
      cyc(4);
   endtask

   // ------------------------------------------------------------------
   // Main sequence.
   // ------------------------------------------------------------------
   initial begin
      fails = 0;
      n_checks = 0;
      {rst_b, por_b, strap, ovr_load, ovr_rber, spl_valid, awvalid, wvalid, bready, arvalid, rready} = '0;
      {ovr_mps, spl_value, spl_scale, awaddr, araddr, wdata, wstrb} = '0;
      clk_en = 1'b1;
      upstream = 1'b1;
      cyc(5);
      rst_b <= 1'b1;
      por_b <= 1'b1;
      cyc(4);
      chk("ctl pins", 32'h0, ctl_img());
      axi_rd(OFS_DEV_CAP, 32'h0000_8001, RESP_OKAY, "cap reset");
      axi_rd(OFS_DEV_CTL, 32'h0, RESP_OKAY, "ctl reset");
      axi_wr(OFS_DEV_CTL, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
      axi_rd(OFS_DEV_CTL, 32'h0000_042F, RESP_OKAY, "ctl ones");
      chk("ctl pins", 32'h0000_042F, ctl_img());
      axi_wr(OFS_DEV_CTL, 32'h0000_0025, 4'hF, RESP_OKAY);
      chk("ctl pins", 32'h0000_0025, ctl_img());
      // Only the second lane strobe is set, so only the aux enable may move.
      axi_wr(OFS_DEV_CTL, 32'hFFFF_FFFF, 4'h2, RESP_OKAY);
      axi_rd(OFS_DEV_CTL, 32'h0000_0425, RESP_OKAY, "ctl lane");
      axi_wr(OFS_DEV_CAP, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
      axi_rd(OFS_DEV_CAP, 32'h0000_8001, RESP_OKAY, "cap written");
      axi_wr(8'h10, 32'hFFFF_FFFF, 4'hF, RESP_SLVERR);
      axi_rd(8'h10, 32'h0, RESP_SLVERR, "unmapped");
      port_reset();
      chk("ctl pins", 32'h0000_0400, ctl_img());
      // An override offered while the clock enable is low must be lost.
      clk_en <= 1'b0;
      ovr_mps <= 3'h4;
      ovr_load <= 1'b1;
      cyc(1);
      ovr_load <= 1'b0;
      clk_en <= 1'b1;
      cyc(1);
      chk("cap pins", 32'h1, {29'h0, mps_cap});
      ovr_mps <= 3'h3;
      ovr_load <= 1'b1;
      cyc(1);
      ovr_load <= 1'b0;
      cyc(1);
      axi_rd(OFS_DEV_CAP, 32'h0000_0003, RESP_OKAY, "cap override");
      axi_wr(OFS_DEV_CTL, 32'h0000_00E0, 4'hF, RESP_OKAY);
      axi_rd(OFS_DEV_CTL, 32'h0000_0060, RESP_OKAY, "ctl clamp");
      spl_value <= 8'hA5;
      spl_scale <= 2'h2;
      spl_valid <= 1'b1;
      cyc(1);
      spl_valid <= 1'b0;
      cyc(1);
      axi_rd(OFS_DEV_CAP, 32'h0A94_0003, RESP_OKAY, "cap slot");
      chk("slot pins", 32'h0000_02A5, {22'h0, slot_scale, slot_value});
      // A downstream port ignores slot power messages.
      upstream <= 1'b0;
      cyc(4);
      spl_value <= 8'h5A;
      spl_scale <= 2'h1;
      spl_valid <= 1'b1;
      cyc(1);
      spl_valid <= 1'b0;
      cyc(1);
      axi_rd(OFS_DEV_CAP, 32'h0A94_0003, RESP_OKAY, "cap downstream");
      strap <= 1'b1;
      upstream <= 1'b1;
      port_reset();
      axi_rd(OFS_DEV_CAP, 32'h0000_8002, RESP_OKAY, "cap strap");
      axi_wr(OFS_DEV_CTL, 32'h0000_0400, 4'h2, RESP_OKAY);
      // The enable must be set here, or the power-on clear below proves nothing.
      chk("aux pin", 32'h1, {31'h0, aux});
      por_b <= 1'b0;
      cyc(2);
      por_b <= 1'b1;
      cyc(1);
      chk("aux pin", 32'h0, {31'h0, aux});
      end_sim();
   end
endmodule
